// ---- bench/flash_dev_model.sv ----
`timescale 1ns/1ps
// =====
// Device model, 16 bytes only
module flash_dev_model
#(
  parameter [7:0] MAKER_ID = 8'h3c, // Arbitrary
  parameter [7:0] PART_ID  = 8'h5a  // Arbitrary
)
(
  input  wire        ref_clk,
  input  wire        supplyOn,
  input  wire        failMode,
  input  wire [16:0] flashAddr,
  input  wire        chipSelectN,
  input  wire        writeStrobeN,
  input  wire        outputGateN,
  input  wire [7:0]  dqOut,
  output reg  [7:0]  dqIn
);
  reg [7:0]  mem [0:15];
  reg [7:0]  pData, v, last;
  reg [16:0] pAddr;
  reg [2:0]  mode;
  reg [3:0]  busyCnt;
  reg        tog;
  integer    i;
  initial
  begin
    mode = 3'd0;
    tog = 1'b0;
    busyCnt = 4'd0;
    last = 8'h00;
    for (i = 0; i < 16; i = i + 1) mem[i] = 8'hff;
  end
  always @(negedge writeStrobeN) if (!chipSelectN) pAddr = flashAddr;
  always @(negedge outputGateN) if (!chipSelectN) tog = ~tog;
  always @(posedge writeStrobeN)
    if (!chipSelectN && outputGateN && supplyOn)
    begin
      pData = dqOut;
      busyCnt = 4'd0;
      if (mode == 3'd1)
      begin
        mode = 3'd2;
        busyCnt = 4'd8;
      end
      else if (mode == 3'd3 && dqOut == 8'h30)
      begin
        mode = 3'd4;
        busyCnt = 4'd8;
      end
      else if (dqOut == 8'h10 || dqOut == 8'h50) mode = 3'd1;
      else if (dqOut == 8'h80 || dqOut == 8'h90) mode = 3'd5;
      else if (dqOut == 8'h30) mode = 3'd3;
      else mode = 3'd0;
    end
  // Failure freezes the operation until a reset write
  // Falling edge, so the status never moves at the host's sampling edge
  always @(negedge ref_clk)
    if (failMode) busyCnt = 4'd0;
    else if (busyCnt != 4'd0)
    begin
      busyCnt = busyCnt - 4'd1;
      if (busyCnt == 4'd0)
      begin
        if (mode == 3'd2) mem[pAddr[3:0]] = mem[pAddr[3:0]] & pData;
        else for (i = 0; i < 16; i = i + 1) mem[i] = 8'hff;
        mode = 3'd0;
      end
    end
  // Released bus shows inverse of last byte, not a stale copy
  always @*
  begin
    case (mode)
      3'd2: v = {~pData[7], tog, failMode, pData[4:0]};
      3'd4: v = {1'b0, tog, failMode, 5'h00};
      3'd5: v = flashAddr[0] ? PART_ID : MAKER_ID;
      default: v = mem[flashAddr[3:0]];
    endcase
    if (mode == 3'd1 || mode == 3'd3) v[6] = tog;
    if (!chipSelectN && !outputGateN) last = v;
    dqIn = (!chipSelectN && !outputGateN) ? v : ~last;
  end
endmodule // flash_dev_model

// ---- bench/flash_host_chk_sva.sv ----
`timescale 1ns/1ps
`include "flash_host_map.vh"
// =====
// Pin and user handshake checks
module flash_host_chk
(
  // Clock and reset
  input wire        ref_clk,
  input wire        rst,
  // User side
  input wire        opValid,
  input wire [2:0]  opCode,
  input wire        supplyOn,
  input wire        opBusy,
  input wire        opDone,
  input wire [1:0]  opResult,
  // Pins
  input wire [16:0] flashAddr,
  input wire        chipSelectN,
  input wire        writeStrobeN,
  input wire        outputGateN,
  input wire [7:0]  dqOut,
  input wire        dqOe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire refuse = opValid && !opBusy && !supplyOn && opCode != `OP_READ;
  sequence weLow2; !writeStrobeN [*2] ##1 writeStrobeN; endsequence
  sequence csIdle3; chipSelectN [*3]; endsequence
  wr_gate_a: assert property (!writeStrobeN |-> !chipSelectN && outputGateN && dqOe)
    else $error("bad write gating");
  oe_excl_a: assert property (!outputGateN |-> !dqOe && writeStrobeN)
    else $error("read overlaps write");
  strobe_width_a: assert property ($fell(writeStrobeN) |-> weLow2)
    else $error("write pulse width");
  addr_hold_a: assert property (!writeStrobeN |-> $stable(flashAddr) && $stable(dqOut))
    else $error("address or data moved");
  cs_frame_a: assert property ($rose(writeStrobeN) |-> !chipSelectN)
    else $error("select left before strobe");
  done_pulse_a: assert property (opDone |=> !opDone)
    else $error("done too long");
  refuse_res_a: assert property (refuse |-> ##[1:3] opDone && opResult == `RES_REFUSED)
    else $error("no refusal");
  refuse_quiet_a: assert property (refuse |-> csIdle3)
    else $error("pins moved on refusal");
  done_idle_a: assert property (opDone |-> chipSelectN && writeStrobeN && outputGateN)
    else $error("done during cycle");
  busy_take_a: assert property (opValid && !opBusy |=> opBusy)
    else $error("request not taken");
  busy_done_a: assert property (opDone |-> !opBusy)
    else $error("busy with done");
endmodule // flash_host_chk
bind flash_host_ctrl flash_host_chk u_chk
(
  .ref_clk(ref_clk), .rst(rst), .opValid(opValid), .opCode(opCode), .supplyOn(supplyOn),
  .opBusy(opBusy), .opDone(opDone), .opResult(opResult), .flashAddr(flashAddr),
  .chipSelectN(chipSelectN), .writeStrobeN(writeStrobeN), .outputGateN(outputGateN),
  .dqOut(dqOut), .dqOe(dqOe)
);

// ---- bench/flash_host_ctrl_tb.sv ----
`timescale 1ns/1ps
`include "flash_host_map.vh"
module flash_host_ctrl_tb;
  localparam [7:0] PART = 8'h5a; // Arbitrary
  reg         ref_clk, rst, opValid, supplyOn, failMode;
  reg  [2:0]  opCode;
  reg  [16:0] opAddr;
  reg  [7:0]  opData, r;
  reg  [3:0]  a;
  reg  [10:0] e;
  reg  [7:0]  shadow [0:15];
  reg  [10:0] expq [$];
  wire        opBusy, opDone, chipSelectN, writeStrobeN, outputGateN, dqOe;
  wire [1:0]  opResult;
  wire [7:0]  opRdata, dqOut, dqIn;
  wire [16:0] flashAddr;
  integer     errors, cmp_count, i, n;
  flash_host_ctrl uut
  (
    .ref_clk(ref_clk), .rst(rst), .opValid(opValid), .opCode(opCode), .opAddr(opAddr),
    .opData(opData), .supplyOn(supplyOn), .opBusy(opBusy), .opDone(opDone),
    .opResult(opResult), .opRdata(opRdata), .flashAddr(flashAddr), .chipSelectN(chipSelectN),
    .writeStrobeN(writeStrobeN), .outputGateN(outputGateN), .dqOut(dqOut), .dqOe(dqOe),
    .dqIn(dqIn)
  );
  flash_dev_model #(.PART_ID(PART)) dev
  (
    .ref_clk(ref_clk), .supplyOn(supplyOn), .failMode(failMode), .flashAddr(flashAddr),
    .chipSelectN(chipSelectN), .writeStrobeN(writeStrobeN), .outputGateN(outputGateN),
    .dqOut(dqOut), .dqIn(dqIn)
  );
  task chk(input [47:0] name, input [7:0] exp, input [7:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (exp !== got)
      begin
        errors = errors + 1;
        $display("[FAIL] %0s exp %h got %h", name, exp, got);
      end
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task op(input [2:0] c, input [3:0] ad, input [7:0] d, input [1:0] res, input rd,
          input [7:0] ed);
    begin
      @(negedge ref_clk);
      opCode = c;
      opAddr = {13'h0000, ad};
      opData = d;
      opValid = 1'b1;
      expq.push_back({rd, res, ed});
      @(negedge ref_clk);
      opValid = 1'b0;
      n = 0;
      while (opDone !== 1'b1 && n < 400)
      begin
        @(negedge ref_clk);
        n = n + 1;
      end
      if (n >= 400)
      begin
        errors = errors + 1;
        stop_test;
      end
    end
  endtask
  // =====
  // Result monitor
  always @(negedge ref_clk)
    if (opDone === 1'b1)
    begin
      if (expq.size() == 0) chk("extra", 8'h00, 8'h01);
      else
      begin
        e = expq.pop_front();
        chk("result", {6'h00, e[9:8]}, {6'h00, opResult});
        if (e[10]) chk("rdata", e[7:0], opRdata);
      end
    end
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial
  begin
    #2000000;
    errors = errors + 1;
    stop_test;
  end
  // =====
  // Main sequence
  initial
  begin
    errors = 0;
    cmp_count = 0;
    rst = 1'b1;
    {opValid, opCode, opAddr, opData, failMode} = 0;
    supplyOn = 1'b1;
    r = $urandom(32'hd8c55ccf);
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    op(`OP_READ, 4'h3, 8'h00, `RES_OK, 1'b1, 8'hff);
    op(`OP_ERASE, 4'h0, 8'h00, `RES_OK, 1'b0, 8'h00);
    for (i = 0; i < 16; i = i + 1) shadow[i] = 8'hff;
    for (i = 0; i < 6; i = i + 1)
    begin
      r = $urandom;
      // Fresh byte for passes 0 to 4; bit 7 kept for the all-ones pass so polling ends
      if (i < 5) a = {i[2:0], r[0]};
      if (i == 4) r[7] = 1'b1;
      if (i == 5) r = 8'hff;
      op(`OP_PROGRAM, a, r, `RES_OK, 1'b0, 8'h00);
      shadow[a] = shadow[a] & r;
      op(`OP_READ, a, 8'h00, `RES_OK, 1'b1, shadow[a]);
    end
    op(`OP_SIGNATURE, 4'h0, 8'h00, `RES_OK, 1'b1, PART);
    op(`OP_RESET, 4'h0, 8'h00, `RES_OK, 1'b0, 8'h00);
    op(`OP_READ, a, 8'h00, `RES_OK, 1'b1, shadow[a]);
    op(`OP_MASK, 4'h0, 8'h00, `RES_OK, 1'b0, 8'h00);
    supplyOn = 1'b0;
    op(`OP_PROGRAM, a, 8'h00, `RES_REFUSED, 1'b0, 8'h00);
    op(`OP_ERASE, a, 8'h00, `RES_REFUSED, 1'b0, 8'h00);
    op(`OP_READ, a, 8'h00, `RES_OK, 1'b1, shadow[a]);
    supplyOn = 1'b1;
    failMode = 1'b1;
    op(`OP_PROGRAM, a, 8'h00, `RES_FAIL, 1'b0, 8'h00);
    failMode = 1'b0;
    op(`OP_RESET, 4'h0, 8'h00, `RES_OK, 1'b0, 8'h00);
    op(`OP_READ, a, 8'h00, `RES_OK, 1'b1, shadow[a]);
    repeat (4) @(negedge ref_clk);
    chk("queue", 8'h00, expq.size());
    stop_test;
  end
endmodule // flash_host_ctrl_tb

// ---- common/flash_host_map.vh ----
`ifndef FLASH_HOST_MAP_VH
`define FLASH_HOST_MAP_VH
// Command codes
`define CMD_READ        8'h00
`define CMD_RESET_ALT   8'hff
`define CMD_PROG_SETUP  8'h10
`define CMD_PROG_ALT    8'h50
`define CMD_SIG_READ    8'h80
`define CMD_SIG_ALT     8'h90
`define CMD_ERASE       8'h30
// Signature addresses
`define SIG_MAKER_ADDR  17'h00000
`define SIG_PART_ADDR   17'h00001
// Status bit positions
`define POLL_BIT        7
`define TOGGLE_BIT      6
`define TIMEOUT_BIT     5
// Bus cycle timing in ns, rounded up to ref_clk cycles (40 ns each)
`define T_SETUP_NS      40
`define T_PULSE_NS      80
`define T_HOLD_NS       40
`define T_ACCESS_NS     120
`define CLK_NS          40
`define N_SETUP   ((`T_SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define N_PULSE   ((`T_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define N_HOLD    ((`T_HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define N_ACCESS  ((`T_ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
// User operation codes
`define OP_READ         3'h0
`define OP_PROGRAM      3'h1
`define OP_ERASE        3'h2
`define OP_SIGNATURE    3'h3
`define OP_RESET        3'h4
`define OP_MASK         3'h5
// Result codes
`define RES_OK          2'h0
`define RES_FAIL        2'h1
`define RES_REFUSED     2'h2
`endif

// ---- logic/flash_bus_cycle.v ----
`timescale 1ns/1ps
`include "flash_host_map.vh"
// ==========================================
// Single write or read cycle on the flash pins
module flash_bus_cycle
(
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Cycle request
  input  wire        start,
  input  wire        isWrite,
  input  wire [16:0] addr,
  input  wire [7:0]  wdata,
  output reg         done,
  output reg  [7:0]  rdata,
  // Flash pins
  output reg  [16:0] flashAddr,
  output reg         chipSelectN,
  output reg         writeStrobeN,
  output reg         outputGateN,
  output reg  [7:0]  dqOut,
  output reg         dqOe,
  input  wire [7:0]  dqIn
);
  localparam S_IDLE  = 2'h0;
  localparam S_SETUP = 2'h1;
  localparam S_PULSE = 2'h2;
  localparam S_HOLD  = 2'h3;
  // Last count of each phase; the low bits feed the 4-bit counter compare
  localparam [31:0] SETUP_END  = `N_SETUP - 1;
  localparam [31:0] PULSE_END  = `N_PULSE - 1;
  localparam [31:0] ACCESS_END = `N_ACCESS - 1;
  localparam [31:0] HOLD_END   = `N_HOLD - 1;
  reg [1:0] state;
  reg [3:0] count;
  reg       writing;

  // ==========================================
  // Strobe sequencer
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state        <= S_IDLE;
      count        <= 4'h0;
      writing      <= 1'b0;
      done         <= 1'b0;
      rdata        <= 8'h00;
      flashAddr    <= 17'h00000;
      chipSelectN  <= 1'b1;
      writeStrobeN <= 1'b1;
      outputGateN  <= 1'b1;
      dqOut        <= 8'h00;
      dqOe         <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (start)
          begin
            flashAddr   <= addr;
            dqOut       <= wdata;
            dqOe        <= isWrite;
            writing     <= isWrite;
            chipSelectN <= 1'b0;
            count       <= 4'h0;
            state       <= S_SETUP;
          end
        end
        S_SETUP:
        begin
          if (count == SETUP_END[3:0])
          begin
            count <= 4'h0;
            // Output gate stays high on writes so the command is accepted
            if (writing)
              writeStrobeN <= 1'b0;
            else
              outputGateN <= 1'b0;
            state <= S_PULSE;
          end
          else
            count <= count + 4'h1;
        end
        S_PULSE:
        begin
          if (count == (writing ? PULSE_END[3:0] : ACCESS_END[3:0]))
          begin
            count        <= 4'h0;
            rdata        <= dqIn;
            writeStrobeN <= 1'b1;
            outputGateN  <= 1'b1;
            state        <= S_HOLD;
          end
          else
            count <= count + 4'h1;
        end
        S_HOLD:
        begin
          if (count == HOLD_END[3:0])
          begin
            chipSelectN <= 1'b1;
            dqOe        <= 1'b0;
            done        <= 1'b1;
            state       <= S_IDLE;
          end
          else
            count <= count + 4'h1;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule // flash_bus_cycle

// ---- logic/flash_host_ctrl.v ----
`timescale 1ns/1ps
`include "flash_host_map.vh"
module flash_host_ctrl
(
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // User orders
  input  wire        opValid,
  input  wire [2:0]  opCode,
  input  wire [16:0] opAddr,
  input  wire [7:0]  opData,
  input  wire        supplyOn,
  output reg         opBusy,
  output reg         opDone,
  output reg  [1:0]  opResult,
  output reg  [7:0]  opRdata,
  // Flash pins
  output wire [16:0] flashAddr,
  output wire        chipSelectN,
  output wire        writeStrobeN,
  output wire        outputGateN,
  output wire [7:0]  dqOut,
  output wire        dqOe,
  input  wire [7:0]  dqIn
);
  localparam S_IDLE   = 3'h0;
  localparam S_CYCLE  = 3'h1;
  localparam S_WAIT   = 3'h2;
  localparam S_DECIDE = 3'h3;
  localparam S_FINISH = 3'h4;

  reg  [2:0]  state;
  reg  [2:0]  op;
  reg  [2:0]  step;
  reg  [16:0] addrHold;
  reg  [7:0]  dataHold;
  reg         failSeen;
  reg         cycStart;
  reg         cycWrite;
  reg  [16:0] cycAddr;
  reg  [7:0]  cycData;
  wire        cycDone;
  wire [7:0]  cycRdata;

  flash_bus_cycle bus
  (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .start        (cycStart),
    .isWrite      (cycWrite),
    .addr         (cycAddr),
    .wdata        (cycData),
    .done         (cycDone),
    .rdata        (cycRdata),
    .flashAddr    (flashAddr),
    .chipSelectN  (chipSelectN),
    .writeStrobeN (writeStrobeN),
    .outputGateN  (outputGateN),
    .dqOut        (dqOut),
    .dqOe         (dqOe),
    .dqIn         (dqIn)
  );

  // Completion test on a status read: true once polling has ended
  wire pollDone = (op == `OP_ERASE) ? cycRdata[`POLL_BIT] :
                  (cycRdata[`POLL_BIT] == dataHold[`POLL_BIT]);
  wire timedOut = cycRdata[`TIMEOUT_BIT];

  // ==========================================
  // Command sequencer
  // step: index into the bus cycles of the running operation
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state    <= S_IDLE;
      op       <= `OP_READ;
      step     <= 3'h0;
      addrHold <= 17'h00000;
      dataHold <= 8'h00;
      failSeen <= 1'b0;
      cycStart <= 1'b0;
      cycWrite <= 1'b0;
      cycAddr  <= 17'h00000;
      cycData  <= 8'h00;
      opBusy   <= 1'b0;
      opDone   <= 1'b0;
      opResult <= `RES_OK;
      opRdata  <= 8'h00;
    end
    else
    begin
      cycStart <= 1'b0;
      opDone   <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (opValid)
          begin
            op       <= opCode;
            addrHold <= opAddr;
            dataHold <= opData;
            step     <= 3'h0;
            failSeen <= 1'b0;
            opBusy   <= 1'b1;
            // Without supply the command latch stays at read; only reads go out
            if (!supplyOn && opCode != `OP_READ)
            begin
              opResult <= `RES_REFUSED;
              state    <= S_FINISH;
            end
            else
              state <= S_CYCLE;
          end
        end
        S_CYCLE:
        begin
          cycStart <= 1'b1;
          state    <= S_WAIT;
          case (op)
            `OP_PROGRAM:
            begin
              cycWrite <= (step < 3'h2);
              cycAddr  <= addrHold;
              cycData  <= (step == 3'h0) ? `CMD_PROG_SETUP : dataHold;
            end
            `OP_ERASE:
            begin
              cycWrite <= (step < 3'h2);
              cycAddr  <= 17'h00000;
              cycData  <= `CMD_ERASE;
            end
            `OP_SIGNATURE:
            begin
              cycWrite <= (step == 3'h0);
              cycAddr  <= (step == 3'h1) ? `SIG_MAKER_ADDR : `SIG_PART_ADDR;
              cycData  <= `CMD_SIG_READ;
            end
            `OP_RESET:
            begin
              // Twice, so program setup state need not be tracked
              cycWrite <= 1'b1;
              cycAddr  <= 17'h00000;
              cycData  <= `CMD_RESET_ALT;
            end
            `OP_MASK:
            begin
              cycWrite <= 1'b1;
              cycAddr  <= 17'h00000;
              cycData  <= `CMD_READ;
            end
            default:
            begin
              cycWrite <= 1'b0;
              cycAddr  <= addrHold;
              cycData  <= 8'h00;
            end
          endcase
        end
        S_WAIT:
        begin
          if (cycDone)
            state <= S_DECIDE;
        end
        S_DECIDE:
        begin
          step  <= step + 3'h1;
          state <= S_CYCLE;
          case (op)
            `OP_PROGRAM, `OP_ERASE:
            begin
              // Status reads start only after the second write pulse
              if (step >= 3'h2)
              begin
                step <= 3'h2;
                if (pollDone)
                begin
                  opResult <= `RES_OK;
                  state    <= S_FINISH;
                end
                else if (timedOut)
                begin
                  // Poll bit may flip with the fail flag; one more read
                  if (failSeen)
                  begin
                    opResult <= `RES_FAIL;
                    state    <= S_FINISH;
                  end
                  failSeen <= 1'b1;
                end
                // Fail flag must show on two reads in a row
                else
                  failSeen <= 1'b0;
              end
            end
            `OP_SIGNATURE:
            begin
              if (step == 3'h1)
                opRdata <= cycRdata;
              if (step == 3'h2)
              begin
                opRdata  <= cycRdata;
                opResult <= `RES_OK;
                state    <= S_FINISH;
              end
            end
            `OP_RESET:
            begin
              if (step == 3'h1)
              begin
                opResult <= `RES_OK;
                state    <= S_FINISH;
              end
            end
            default:
            begin
              opRdata  <= cycRdata;
              opResult <= `RES_OK;
              state    <= S_FINISH;
            end
          endcase
        end
        S_FINISH:
        begin
          opBusy <= 1'b0;
          opDone <= 1'b1;
          state  <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule // flash_host_ctrl
